// >>> verif/psis_host_model.sv
`timescale 1ns/1ps
module psis_host_model (
  input wire logic clk,
  input wire logic goReq,
  input wire logic [1:0] goSlot,
  output logic hostWrite,
  output logic [1:0] hostWriteSlot
);
  initial hostWrite = 1'b0;
  initial hostWriteSlot = 2'h0;
  // slot lines float between writes: drive the inverse so a stale slot never looks valid
  always @(posedge clk)
  begin
    hostWrite <= goReq;
    hostWriteSlot <= goReq ? goSlot : ~hostWriteSlot;
  end
endmodule : psis_host_model

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic goReq = 1'b0;
  logic [1:0] goSlot = 2'h0;
  logic swRead = 1'b0;
  logic [1:0] swReadSlot = 2'h0;
  logic hostWrite, allInputsFull, inputOverflowFlag, irq;
  logic [1:0] hostWriteSlot, rs;
  logic [3:0] inputSlotFull;
  logic [31:0] rv;
  psis_pkg::psis_axi_req_s req = '0;
  psis_pkg::psis_axi_rsp_s rsp;
  int mismatches = 0;
  int checked = 0;
  localparam logic [15:0] A_ST = {psis_pkg::STAT_IDX, 2'b00};
  localparam logic [15:0] A_IS = {psis_pkg::IRQ_STAT_IDX, 2'b00};
  localparam logic [15:0] A_IM = {psis_pkg::IRQ_MASK_IDX, 2'b00};
  localparam int LIMIT = 50;
  always #5 clk = ~clk;
  psis_host_model i_host (.clk(clk), .goReq(goReq), .goSlot(goSlot), .hostWrite(hostWrite),
    .hostWriteSlot(hostWriteSlot));
  psis_input_status i_dut (.clk(clk), .rst(rst), .ce(ce), .axiReq(req), .axiRsp(rsp),
    .hostWrite(hostWrite), .hostWriteSlot(hostWriteSlot), .swRead(swRead),
    .swReadSlot(swReadSlot), .inputSlotFull(inputSlotFull), .allInputsFull(allInputsFull),
    .inputOverflowFlag(inputOverflowFlag), .irq(irq));
  task automatic results;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic expire(input int n);
    if (n >= LIMIT)
    begin
      mismatches++;
      results();
    end
  endtask : expire
  // readies are sampled at the rising edge; aw and w are released each on its own ready
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    int n;
    logic awOpen;
    logic wOpen;
    n = 0;
    awOpen = 1'b1;
    wOpen = 1'b1;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while ((awOpen || wOpen) && n < LIMIT)
    begin
      @(posedge clk);
      n++;
      if (awOpen && rsp.awready === 1'b1)
      begin
        awOpen = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (wOpen && rsp.wready === 1'b1)
      begin
        wOpen = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.bvalid !== 1'b1 && n < LIMIT);
    rs = rsp.bresp;
    req.bready <= 1'b0;
    expire(n);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    int n;
    n = 0;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.arready !== 1'b1 && n < LIMIT);
    req.arvalid <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.rvalid !== 1'b1 && n < LIMIT);
    rv = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
    expire(n);
  endtask : rd
  task automatic hw(input logic [1:0] s);
    @(posedge clk);
    goReq <= 1'b1; goSlot <= s;
    @(posedge clk);
    goReq <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : hw
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(A_ST);
    chk("status", 32'h0, rv);
    for (int i = 0; i < 4; i++)
    begin
      hw(i[1:0]);
      chk("allFull", {31'h0, i == 3}, {31'h0, allInputsFull});
    end
    chk("slotFull", 32'hF, {28'h0, inputSlotFull});
    rd(A_ST);
    chk("status", 32'h8F, rv);
    hw(2'h2);
    chk("ovf", 32'h1, {31'h0, inputOverflowFlag});
    chk("slotFull", 32'hF, {28'h0, inputSlotFull});
    rd(A_ST);
    chk("status", 32'hCF, rv);
    rd(A_IS);
    chk("irqStat", 32'h3, rv);
    chk("irq", 32'h0, {31'h0, irq});
    wr(A_IM, 32'h3);
    @(negedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(A_IM);
    chk("irqMask", 32'h3, rv);
    @(posedge clk);
    swRead <= 1'b1;
    swReadSlot <= 2'h1;
    @(posedge clk);
    swRead <= 1'b0;
    rd(A_ST);
    chk("status", 32'h4D, rv);
    wr(A_ST, 32'h70);
    rd(A_ST);
    chk("status", 32'h4D, rv);
    wr(A_ST, 32'h0);
    rd(A_ST);
    chk("status", 32'h0D, rv);
    // host write and software read of one full slot in the same cycle
    @(posedge clk);
    goReq <= 1'b1;
    goSlot <= 2'h0;
    @(posedge clk);
    goReq <= 1'b0;
    swRead <= 1'b1;
    swReadSlot <= 2'h0;
    @(posedge clk);
    swRead <= 1'b0;
    @(negedge clk);
    chk("slotFull", 32'hD, {28'h0, inputSlotFull});
    chk("ovf", 32'h0, {31'h0, inputOverflowFlag});
    // a read while the enable is low must leave the slot full
    @(posedge clk);
    ce <= 1'b0;
    swRead <= 1'b1;
    swReadSlot <= 2'h0;
    @(posedge clk);
    ce <= 1'b1;
    swRead <= 1'b0;
    @(negedge clk);
    chk("slotFull", 32'hD, {28'h0, inputSlotFull});
    wr(A_IS, 32'h3);
    @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(16'h0010);
    chk("rresp", 32'h2, {30'h0, rs});
    chk("rdata", 32'h0, rv);
    wr(16'h0010, 32'h0);
    chk("bresp", 32'h2, {30'h0, rs});
    hw(2'h0);
    chk("ovf", 32'h1, {31'h0, inputOverflowFlag});
    chk("irq", 32'h1, {31'h0, irq});
    // second reset in mid-run clears flags, status and mask
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(A_ST);
    chk("status", 32'h0, rv);
    rd(A_IM);
    chk("irqMask", 32'h0, rv);
    chk("irq", 32'h0, {31'h0, irq});
    results();
  end
endmodule : testbench

// >>> verilog/psis_input_status.sv
// Function
// - bit 7 high when all four full
// - write to full buffer sets bit 6, unless that buffer is also read in the same cycle
// - overflow stays until software writes zero
// - per-buffer full flags, cleared by read
// - bits 5 and 4 read zero
`timescale 1ns/1ps
module psis_input_status (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire psis_pkg::psis_axi_req_s axiReq,
  output psis_pkg::psis_axi_rsp_s axiRsp,
  input wire logic hostWrite,
  input wire logic [1:0] hostWriteSlot,
  input wire logic swRead,
  input wire logic [1:0] swReadSlot,
  output logic [3:0] inputSlotFull,
  output logic allInputsFull,
  output logic inputOverflowFlag,
  output logic irq
);

  function automatic logic [3:0] slotDecode(input logic en, input logic [1:0] slot);
    slotDecode = en ? (4'h1 << slot) : 4'h0;
  endfunction : slotDecode

  psis_pkg::psis_state_s s_q;
  psis_pkg::psis_state_s s_d;

  logic [3:0] hostHit;
  logic [3:0] swHit;
  logic ovfEvt;
  logic wrTake;
  logic ovfClear;
  logic [13:0] wIdx;
  logic [13:0] rIdx;
  logic [7:0] statByte;

  assign wIdx = axiReq.awaddr[15:2];
  assign rIdx = axiReq.araddr[15:2];
  assign wrTake = s_q.rsp.awready;
  // a read in the same cycle frees the slot, so the incoming byte is no overflow
  assign hostHit = slotDecode(hostWrite, hostWriteSlot);
  assign swHit = slotDecode(swRead, swReadSlot);
  assign ovfEvt = |(hostHit & s_q.full & ~swHit);
  assign ovfClear = wrTake && wIdx == psis_pkg::STAT_IDX && axiReq.wstrb[0]
                    && !axiReq.wdata[psis_pkg::OVF_BIT];
  // reserved bits forced low
  assign statByte = {s_q.allFull, s_q.ovf, 2'h0, s_q.full};

  always_comb
  begin
    s_d = s_q;
    s_d.rsp.awready = 1'b0;
    s_d.rsp.wready = 1'b0;
    s_d.rsp.arready = 1'b0;
    if (s_q.rsp.bvalid && axiReq.bready)
    begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (s_q.rsp.rvalid && axiReq.rready)
    begin
      s_d.rsp.rvalid = 1'b0;
    end
    // both channels are taken together, so each must wait for the other
    if (axiReq.awvalid && axiReq.wvalid && !s_q.rsp.bvalid && !s_q.rsp.awready)
    begin
      s_d.rsp.awready = 1'b1;
      s_d.rsp.wready = 1'b1;
    end
    if (axiReq.arvalid && !s_q.rsp.rvalid && !s_q.rsp.arready)
    begin
      s_d.rsp.arready = 1'b1;
    end
    if (wrTake)
    begin
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = psis_pkg::RESP_OKAY;
      case (wIdx)
        psis_pkg::STAT_IDX:
        begin
        end
        psis_pkg::IRQ_STAT_IDX:
        begin
          if (axiReq.wstrb[0])
          begin
            s_d.irqStat = s_q.irqStat & ~axiReq.wdata[1:0];
          end
        end
        psis_pkg::IRQ_MASK_IDX:
        begin
          if (axiReq.wstrb[0])
          begin
            s_d.irqMask = axiReq.wdata[1:0];
          end
        end
        default:
        begin
          s_d.rsp.bresp = psis_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_q.rsp.arready)
    begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rresp = psis_pkg::RESP_OKAY;
      case (rIdx)
        psis_pkg::STAT_IDX:
        begin
          s_d.rsp.rdata = {24'h000000, statByte};
        end
        psis_pkg::IRQ_STAT_IDX:
        begin
          s_d.rsp.rdata = {30'h0, s_q.irqStat};
        end
        psis_pkg::IRQ_MASK_IDX:
        begin
          s_d.rsp.rdata = {30'h0, s_q.irqMask};
        end
        default:
        begin
          s_d.rsp.rdata = 32'h00000000;
          s_d.rsp.rresp = psis_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_d.full = (s_q.full & ~swHit) | hostHit;
    // hardware never clears the flag; a new overflow beats a software clear
    if (ovfClear)
    begin
      s_d.ovf = 1'b0;
    end
    if (ovfEvt)
    begin
      s_d.ovf = 1'b1;
    end
    // summary taken from the next flags so it moves in the same cycle
    s_d.allFull = &s_d.full;
    if (ovfEvt)
    begin
      s_d.irqStat[psis_pkg::IRQ_OVF_BIT] = 1'b1;
    end
    if (s_d.allFull && !s_q.allFull)
    begin
      s_d.irqStat[psis_pkg::IRQ_FULL_BIT] = 1'b1;
    end
    s_d.irq = |(s_d.irqStat & s_d.irqMask);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.full <= psis_pkg::STAT_RESET[3:0];
      s_q.ovf <= psis_pkg::STAT_RESET[psis_pkg::OVF_BIT];
      s_q.allFull <= psis_pkg::STAT_RESET[psis_pkg::ALL_FULL_BIT];
      s_q.irqStat <= psis_pkg::IRQ_RESET;
      s_q.irqMask <= psis_pkg::IRQ_RESET;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign axiRsp = s_q.rsp;
  assign inputSlotFull = s_q.full;
  assign allInputsFull = s_q.allFull;
  assign inputOverflowFlag = s_q.ovf;
  assign irq = s_q.irq;

  a_summary_and_full: assert property (@(posedge clk) disable iff (rst)
    allInputsFull == (&inputSlotFull))
    else $error("summary flag disagrees with slot flags");

  a_summary_same_cycle: assert property (@(posedge clk) disable iff (rst)
    ce && (&s_d.full) && !allInputsFull |=> allInputsFull)
    else $error("summary flag lagged slot flags");

  a_overflow_set_on: assert property (@(posedge clk) disable iff (rst)
    ce && hostWrite && inputSlotFull[hostWriteSlot]
    && !(swRead && swReadSlot == hostWriteSlot) |=> inputOverflowFlag)
    else $error("overflow not flagged");

  a_overflow_sticky_hold: assert property (@(posedge clk) disable iff (rst)
    inputOverflowFlag && !(ce && ovfClear) |=> inputOverflowFlag)
    else $error("overflow flag dropped by itself");

  a_overflow_sw_clear: assert property (@(posedge clk) disable iff (rst)
    ce && ovfClear && !ovfEvt |=> !inputOverflowFlag)
    else $error("overflow flag not cleared by software");

  a_irq_level_match: assert property (@(posedge clk) disable iff (rst)
    irq == |(s_q.irqStat & s_q.irqMask))
    else $error("interrupt output disagrees with status and mask");

  a_slot_read_clear: assert property (@(posedge clk) disable iff (rst)
    ce && swRead && !(hostWrite && hostWriteSlot == swReadSlot)
    |=> !inputSlotFull[$past(swReadSlot)])
    else $error("slot flag not cleared by read");

  a_slot_write_set: assert property (@(posedge clk) disable iff (rst)
    ce && hostWrite |=> inputSlotFull[$past(hostWriteSlot)])
    else $error("slot flag not set by write");

  a_reserved_read_zero: assert property (@(posedge clk) disable iff (rst)
    ce && s_q.rsp.arready && rIdx == psis_pkg::STAT_IDX |=> axiRsp.rdata[5:4] == 2'h0)
    else $error("reserved status bits not zero");

  a_write_gets_resp: assert property (@(posedge clk) disable iff (rst)
    ce && axiRsp.awready |=> axiRsp.bvalid)
    else $error("write response missing");

  c_overflow_seen: cover property (@(posedge clk) disable iff (rst) $rose(inputOverflowFlag));
  c_all_full_seen: cover property (@(posedge clk) disable iff (rst) $rose(allInputsFull));
  c_irq_raised: cover property (@(posedge clk) disable iff (rst) $rose(irq));
  c_same_slot_pair: cover property (@(posedge clk) disable iff (rst)
    ce && hostWrite && swRead && hostWriteSlot == swReadSlot);
  c_overflow_cleared: cover property (@(posedge clk) disable iff (rst) $fell(inputOverflowFlag));

endmodule : psis_input_status

// >>> verilog/psis_pkg.sv
package psis_pkg;
  localparam logic [13:0] STAT_IDX = 14'h0F55;
  localparam logic [13:0] IRQ_STAT_IDX = 14'h0F56;
  localparam logic [13:0] IRQ_MASK_IDX = 14'h0F57;
  localparam int ALL_FULL_BIT = 7;
  localparam int OVF_BIT = 6;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_FULL_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [15:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [15:0] araddr;
    logic rready;
  } psis_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } psis_axi_rsp_s;

  typedef struct packed {
    psis_axi_rsp_s rsp;
    logic [3:0] full;
    logic ovf;
    logic allFull;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic irq;
  } psis_state_s;
endpackage : psis_pkg
